// *** design/sleep_mode_clock_gating.sv ***
`timescale 1ns/1ps
// Function
// - Six software-chosen sleep modes, chosen before sleep entry.
// - Idle: core clock stops; peripherals, memory, timers, interrupts run.
// - Power-down: oscillator frozen, all stopped; only external interrupt or reset wakes.
// - Power-save: asynchronous timer keeps running, rest as power-down.
// - ADC quiet: core and peripherals stop except asynchronous timer and converter.
// - Standby: oscillator runs, everything else sleeps, fast wake.
// - Extended standby: oscillator and asynchronous timer run, rest sleeps.
module sleep_mode_clock_gating
  import sleep_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] mode_sel, // Mode chosen by software
  input wire logic sleep_req, // Core sleep request pulse
  input wire logic [3:0] wake_src, // Wake events: ext, io, adc, async
  output logic core_clk_en, // Core clock enable
  output logic io_clk_en, // Peripheral clock enable
  output logic adc_clk_en, // Converter clock enable
  output logic async_clk_en, // Asynchronous timer enable
  output logic osc_en, // Main oscillator enable
  output logic asleep // Sleep in progress
);
  sleep_state_t state_q;
  logic [2:0] mode_q;
  logic [4:0] dom_q;
  logic [7:0] cnt_q;
  logic [4:0] dom_keep;
  logic [3:0] wake_ok;
  logic osc_off;
  logic legal;
  logic wake_hit;

  sleep_mode_decode u_dec (
    .mode(mode_q),
    .dom_keep(dom_keep),
    .wake_ok(wake_ok),
    .osc_off(osc_off),
    .legal(legal)
  );

  logic [4:0] sel_keep;
  logic sel_legal;
  sleep_mode_decode u_sel (
    .mode(mode_sel),
    .dom_keep(sel_keep),
    .wake_ok(),
    .osc_off(),
    .legal(sel_legal)
  );

  assign wake_hit = |(wake_src & wake_ok);

  // Mode latched at sleep entry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_IDLE;
    end else if (state_q == ST_RUN && sleep_req && sel_legal) begin
      mode_q <= mode_sel;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      cnt_q <= CNT_RESET;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (sleep_req && sel_legal) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // A bad latched mode falls back through wake
          if (wake_hit || !legal) begin
            state_q <= ST_WAKE;
            cnt_q <= osc_off ? OSC_START_CYC_W : CNT_RESET;
          end
        end
        ST_WAKE: begin
          if (cnt_q == CNT_RESET) begin
            state_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Domain enables; core follows the others back on wake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dom_q <= DOM_RESET;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (sleep_req && sel_legal) begin
            dom_q <= sel_keep;
          end else begin
            dom_q <= DOM_RESET;
          end
        end
        ST_SLEEP: begin
          if (wake_hit || !legal) begin
            dom_q <= DOM_RESET & ~(5'h01 << DOM_CORE);
          end else begin
            dom_q <= dom_keep;
          end
        end
        ST_WAKE: begin
          if (cnt_q == CNT_RESET) begin
            dom_q <= DOM_RESET;
          end else begin
            dom_q <= DOM_RESET & ~(5'h01 << DOM_CORE);
          end
        end
        default: begin
          dom_q <= DOM_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      async_clk_en <= 1'b1;
      osc_en <= 1'b1;
      asleep <= 1'b0;
    end else begin
      core_clk_en <= dom_q[DOM_CORE];
      io_clk_en <= dom_q[DOM_IO];
      adc_clk_en <= dom_q[DOM_ADC];
      async_clk_en <= dom_q[DOM_ASYNC];
      osc_en <= dom_q[DOM_OSC];
      asleep <= (state_q != ST_RUN);
    end
  end
endmodule : sleep_mode_clock_gating

// *** shared/sleep_pkg.sv ***
package sleep_pkg;
  // Sleep mode selector
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_ADC_QUIET = 3'b001,
    MODE_POWER_DOWN = 3'b010,
    MODE_POWER_SAVE = 3'b011,
    MODE_STANDBY = 3'b110,
    MODE_EXT_STANDBY = 3'b111
  } sleep_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } sleep_state_t;

  // Domain enable vector bit positions
  localparam int DOM_CORE = 0;
  localparam int DOM_IO = 1;
  localparam int DOM_ADC = 2;
  localparam int DOM_ASYNC = 3;
  localparam int DOM_OSC = 4;
  localparam int DOM_W = 5;
  localparam logic [4:0] DOM_RESET = 5'h1f;

  // Wake source bit positions
  localparam int WAKE_EXT = 0;
  localparam int WAKE_IO = 1;
  localparam int WAKE_ADC = 2;
  localparam int WAKE_ASYNC = 3;
  localparam int WAKE_W = 4;

  // Restart delay when the oscillator was stopped
  localparam int OSC_START_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OSC_START_CYC_W = 8'(OSC_START_CYC);
  localparam logic [7:0] CNT_RESET = 8'h00;
endpackage : sleep_pkg

// *** design/sleep_mode_decode.sv ***
`timescale 1ns/1ps
module sleep_mode_decode
  import sleep_pkg::*;
(
  input wire logic [2:0] mode, // Selected mode
  output logic [4:0] dom_keep, // Domains kept running in sleep
  output logic [3:0] wake_ok, // Wake sources allowed
  output logic osc_off, // Oscillator stops
  output logic legal // Mode code is valid
);
  always_comb begin
    dom_keep = 5'h00;
    wake_ok = 4'h1;
    osc_off = 1'b0;
    legal = 1'b1;
    case (mode)
      MODE_IDLE: begin
        dom_keep = 5'h1e;
        wake_ok = 4'hf;
      end
      MODE_ADC_QUIET: begin
        dom_keep = 5'h1c;
        wake_ok = 4'hd;
      end
      MODE_POWER_DOWN: begin
        dom_keep = 5'h00;
        wake_ok = 4'h1;
        osc_off = 1'b1;
      end
      MODE_POWER_SAVE: begin
        dom_keep = 5'h08;
        wake_ok = 4'h9;
        osc_off = 1'b1;
      end
      MODE_STANDBY: begin
        dom_keep = 5'h10;
        wake_ok = 4'h1;
      end
      MODE_EXT_STANDBY: begin
        dom_keep = 5'h18;
        wake_ok = 4'h9;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule : sleep_mode_decode

// *** tb/gating_asserts.sv ***
`timescale 1ns/1ps
module gating_asserts
  import sleep_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] mode_sel, // Mode chosen by software
  input wire logic sleep_req, // Core sleep request
  input wire logic core_clk_en, // Core clock enable
  input wire logic io_clk_en, // Peripheral clock enable
  input wire logic adc_clk_en, // Converter clock enable
  input wire logic async_clk_en, // Asynchronous timer enable
  input wire logic osc_en, // Main oscillator enable
  input wire logic asleep // Sleep in progress
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property keep(logic [2:0] m, logic [4:0] p);
    sleep_req && !asleep && mode_sel == m |->
      ##2 {core_clk_en, io_clk_en, adc_clk_en, async_clk_en, osc_en} == p;
  endproperty
  a_idle_keep: assert property (keep(MODE_IDLE, 5'h0f)) else $error("idle");
  a_quiet_keep: assert property (keep(MODE_ADC_QUIET, 5'h07)) else $error("quiet");
  a_down_keep: assert property (keep(MODE_POWER_DOWN, 5'h00)) else $error("down");
  a_save_keep: assert property (keep(MODE_POWER_SAVE, 5'h02)) else $error("save");
  a_stby_keep: assert property (keep(MODE_STANDBY, 5'h01)) else $error("stby");
  a_ext_keep: assert property (keep(MODE_EXT_STANDBY, 5'h03)) else $error("ext");
  a_core_last: assert property ($rose(core_clk_en) |->
    io_clk_en && adc_clk_en && async_clk_en && osc_en) else $error("order");
  a_entry_req: assert property ($rose(asleep) |-> $past(sleep_req, 2))
    else $error("entry");
  c_sleep: cover property ($rose(asleep));
  c_wake: cover property ($rose(core_clk_en));
  c_osc_off: cover property (asleep && !osc_en);
endmodule : gating_asserts
bind sleep_mode_clock_gating gating_asserts u_chk (.clock(clock), .rst(rst),
  .mode_sel(mode_sel), .sleep_req(sleep_req), .core_clk_en(core_clk_en),
  .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en), .async_clk_en(async_clk_en),
  .osc_en(osc_en), .asleep(asleep));

// *** tb/core_model.sv ***
`timescale 1ns/1ps
module core_model (
  input wire logic clock, // System clock
  input wire logic rst, // Reset
  input wire logic core_clk_en, // Gated core clock
  output logic [15:0] ticks // Core cycles executed
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ticks <= 16'h0000;
    else if (core_clk_en) ticks <= ticks + 16'h0001;
  end
endmodule : core_model

// *** tb/sleep_mode_clock_gating_tb.sv ***
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb;
  import sleep_pkg::*;
  logic clock = 0, rst = 1, sleep_req = 0, asleep;
  logic [2:0] mode_sel = 3'h0;
  logic [3:0] wake_src = 4'h0;
  logic [4:0] en;
  logic [15:0] ticks;
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #12.5 clock = ~clock;
  sleep_mode_clock_gating DUT (.clock(clock), .rst(rst), .mode_sel(mode_sel),
    .sleep_req(sleep_req), .wake_src(wake_src), .core_clk_en(en[4]),
    .io_clk_en(en[3]), .adc_clk_en(en[2]), .async_clk_en(en[1]),
    .osc_en(en[0]), .asleep(asleep));
  core_model u_core (.clock(clock), .rst(rst), .core_clk_en(en[4]), .ticks(ticks));
  task tick(int n); repeat (n) @(posedge clock); #1; endtask : tick
  task chk(logic ok, string m);
    num_checks++;
    if (ok !== 1'b1) begin miscompares++; $display("MISMATCH %0t %s", $time, m); end
  endtask : chk
  task go_sleep(logic [2:0] m, logic [4:0] p);
    logic [15:0] t;
    mode_sel = m; sleep_req = 1; tick(1); sleep_req = 0; tick(2);
    chk(en === p && asleep === 1'b1, "entry");
    t = ticks; tick(4); chk(ticks === t, "core ran");
  endtask : go_sleep
  task wake(int b, int lat);
    int n;
    n = 0; wake_src[b] = 1;
    while (en[4] !== 1'b1 && n < 80) begin tick(1); n++; end
    wake_src = 4'h0;
    chk(en === 5'h1f, "wake");
    chk(n == lat, "wake latency");
    tick(2);
    chk(asleep === 1'b0, "run");
  endtask : wake
  task refuse(int b);
    wake_src[b] = 1; tick(60); wake_src = 4'h0;
    chk(asleep === 1'b1 && en[4] === 1'b0, "woke");
  endtask : refuse
  task t_light;
    go_sleep(MODE_IDLE, 5'h0f); wake(1, 3);
    go_sleep(MODE_ADC_QUIET, 5'h07); refuse(1); wake(2, 3);
    $display("light done");
  endtask : t_light
  task t_deep;
    go_sleep(MODE_POWER_DOWN, 5'h00); refuse(1); wake(0, OSC_START_CYC + 3);
    go_sleep(MODE_POWER_SAVE, 5'h02); refuse(2); wake(3, OSC_START_CYC + 3);
    $display("deep done");
  endtask : t_deep
  task t_standby;
    go_sleep(MODE_STANDBY, 5'h01); refuse(3); wake(0, 3);
    go_sleep(MODE_EXT_STANDBY, 5'h03); wake(3, 3);
    $display("standby done");
  endtask : t_standby
  task t_illegal;
    mode_sel = 3'h4; sleep_req = 1; tick(1); sleep_req = 0; tick(4);
    chk(en === 5'h1f && asleep === 1'b0, "illegal");
    $display("illegal done");
  endtask : t_illegal
  task t_busy;
    go_sleep(MODE_POWER_SAVE, 5'h02);
    mode_sel = MODE_IDLE;
    sleep_req = 1;
    tick(1);
    sleep_req = 0;
    tick(3);
    chk(en === 5'h02 && asleep === 1'b1, "busy request");
    wake(3, OSC_START_CYC + 3);
    $display("busy done");
  endtask : t_busy
  task t_rst_wake;
    go_sleep(MODE_POWER_DOWN, 5'h00);
    rst = 1;
    tick(1);
    rst = 0;
    chk(en === 5'h1f && asleep === 1'b0, "reset wake");
    go_sleep(MODE_IDLE, 5'h0f);
    wake(0, 3);
    $display("reset wake done");
  endtask : t_rst_wake
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin miscompares++; end_sim; end
  end
  initial begin
    tick(6); rst = 0;
    chk(en === 5'h1f && asleep === 1'b0, "reset");
    t_light; t_deep; t_standby; t_illegal; t_busy; t_rst_wake; end_sim;
  end
endmodule : sleep_mode_clock_gating_tb
